/* core/torque_command_mode_select.sv */
// Torque command selection and control mode switching for a servo drive.
// Assumes synchronous digital inputs and a registered analog sample each cycle.
//
// Function
// [R1] Analog mode, selectors 00: torque from analog input, span +/-10 V.
// [R2] Zeroed torque mode, selectors 00: torque command is zero.
// [R3] Selectors 01/10/11 pick preset one/two/three, each +/-470 percent.
// [R4] Selector input OFF reads as 0, ON reads as 1.
// [R5] Preset applies at once on selector change, no trigger needed.
// [R6] In speed behaviour the selected command becomes the torque limit.
// [R7] Torque mode: percent = volts times full-scale over ten; 0..1000, default 100.
// [R8] Speed and position modes: limit = volts times full-scale over ten.
// [R9] Scaled analog command passes a low-pass filter.
// [R10] Code 06: position/speed dual mode switched by an input.
// [R11] Code 07: position/torque dual mode switched by an input.
// [R12] Code 0A: speed/torque dual mode switched by an input.
// [R13] No dual mode combining zeroed speed and zeroed torque.
// [R14] Speed/torque dual: switch ON gives torque behaviour with torque selectors.
// [R15] Speed/torque dual: switch OFF gives speed behaviour with speed selectors.
// [R16] Position/speed dual: pulses for position, analog or presets for speed.
// [R17] Position/torque dual: pulses for position, analog or presets for torque.
// [R18] Controller drives the torque selectors to choose the command once enabled.
// [R19] Default input and output pin functions follow the selected mode.
// [R20] Inputs sampled each cycle; change acts by the next cycle. Here outputs follow an input change two cycles later.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module torque_command_mode_select (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Digital inputs
  input wire logic torqueSrcSel0,
  input wire logic torqueSrcSel1,
  input wire logic speedSrcSel0,
  input wire logic speedSrcSel1,
  input wire logic modeSwitch,
  // Analog sample, signed centivolts
  input wire logic signed [15:0] analogVolts,
  // Results
  output logic signed [15:0] torqueCommand,
  output logic signed [15:0] torqueLimit,
  output logic torqueLimitActive,
  output logic [1:0] speedSelect,
  output logic speedFromAnalog,
  output logic pulsePositionActive,
  output logic [1:0] behaviour,
  output logic [3:0] inputMap
);

  ////////////////////////////////////////////////////////////////////////////////

  logic [15:0] fullScale;
  logic signed [15:0] presetOne;
  logic signed [15:0] presetTwo;
  logic signed [15:0] presetThree;
  logic signed [15:0] speedPresetOne;
  logic signed [15:0] speedPresetTwo;
  logic signed [15:0] speedPresetThree;
  logic [7:0] modeSetting;
  logic modeError;
  logic [1:0] tsel;
  logic [1:0] ssel;
  logic sw;
  logic signed [15:0] volts;
  logic signed [31:0] filtAcc;
  torque_sel_pkg::behaviour_t next_beh;
  logic next_zeroed;
  logic signed [15:0] scaled;
  logic signed [15:0] selected;
  logic [15:0] idx;
  logic access;
  logic mapped;
  logic writeStrobe;
  logic [31:0] next_prdata;
  logic signed [15:0] voltsClamped;
  logic signed [15:0] presetClamped;

  assign idx = paddr[torque_sel_pkg::ADDR_SHIFT +: 16];
  assign access = psel && penable;
  assign pready = 1'b1;
  assign writeStrobe = access && pwrite && !pslverr;

  always_comb begin
    unique case (idx)
      torque_sel_pkg::IDX_FULL_SCALE, torque_sel_pkg::IDX_PRESET_ONE,
      torque_sel_pkg::IDX_PRESET_TWO, torque_sel_pkg::IDX_PRESET_THREE,
      torque_sel_pkg::IDX_SPEED_PRESET_ONE, torque_sel_pkg::IDX_SPEED_PRESET_TWO,
      torque_sel_pkg::IDX_SPEED_PRESET_THREE, torque_sel_pkg::IDX_MODE,
      torque_sel_pkg::IDX_STATUS, torque_sel_pkg::IDX_TORQUE_OUT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped or misaligned access answers with an error
  assign pslverr = access && (!mapped ||
    paddr[torque_sel_pkg::ADDR_SHIFT - 1:0] != '0 ||
    paddr[31:torque_sel_pkg::ADDR_SHIFT + 16] != '0);

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Both clamps saturate symmetrically rather than wrap
  sym_clamp #(
    .WIDTH(16)
  ) u_volts_clamp (
    .din(analogVolts),
    .bound(torque_sel_pkg::ANALOG_MAX),
    .dout(voltsClamped)
  ); // [R1]

  sym_clamp #(
    .WIDTH(16)
  ) u_preset_clamp (
    .din($signed(pwdata[15:0])),
    .bound(torque_sel_pkg::PRESET_MAX),
    .dout(presetClamped)
  ); // [R3]

  // Out-of-range settings saturate at the top of the range [R7]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fullScale <= torque_sel_pkg::FULL_SCALE_RESET;
    end else if (writeStrobe && idx == torque_sel_pkg::IDX_FULL_SCALE) begin
      fullScale <= (pwdata[15:0] > torque_sel_pkg::FULL_SCALE_MAX) ?
        torque_sel_pkg::FULL_SCALE_MAX : pwdata[15:0]; // [R7]
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      presetOne <= 16'sh0000;
      presetTwo <= 16'sh0000;
      presetThree <= 16'sh0000;
    end else if (writeStrobe) begin
      unique case (idx)
        torque_sel_pkg::IDX_PRESET_ONE: presetOne <= presetClamped; // [R3]
        torque_sel_pkg::IDX_PRESET_TWO: presetTwo <= presetClamped; // [R3]
        torque_sel_pkg::IDX_PRESET_THREE: presetThree <= presetClamped; // [R3]
        default: begin
        end
      endcase
    end
  end

  // Speed presets are only stored; the speed loop reads them elsewhere
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      speedPresetOne <= 16'sh0000;
      speedPresetTwo <= 16'sh0000;
      speedPresetThree <= 16'sh0000;
    end else if (writeStrobe) begin
      unique case (idx)
        torque_sel_pkg::IDX_SPEED_PRESET_ONE: speedPresetOne <= $signed(pwdata[15:0]);
        torque_sel_pkg::IDX_SPEED_PRESET_TWO: speedPresetTwo <= $signed(pwdata[15:0]);
        torque_sel_pkg::IDX_SPEED_PRESET_THREE: speedPresetThree <= $signed(pwdata[15:0]);
        default: begin
        end
      endcase
    end
  end

  // Unlisted codes are kept so software can read back what it wrote
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      modeSetting <= torque_sel_pkg::MODE_RESET;
    end else if (writeStrobe && idx == torque_sel_pkg::IDX_MODE) begin
      modeSetting <= pwdata[7:0];
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (idx)
      torque_sel_pkg::IDX_FULL_SCALE: next_prdata[15:0] = fullScale;
      torque_sel_pkg::IDX_PRESET_ONE: next_prdata[15:0] = presetOne;
      torque_sel_pkg::IDX_PRESET_TWO: next_prdata[15:0] = presetTwo;
      torque_sel_pkg::IDX_PRESET_THREE: next_prdata[15:0] = presetThree;
      torque_sel_pkg::IDX_SPEED_PRESET_ONE: next_prdata[15:0] = speedPresetOne;
      torque_sel_pkg::IDX_SPEED_PRESET_TWO: next_prdata[15:0] = speedPresetTwo;
      torque_sel_pkg::IDX_SPEED_PRESET_THREE: next_prdata[15:0] = speedPresetThree;
      torque_sel_pkg::IDX_MODE: next_prdata[7:0] = modeSetting;
      torque_sel_pkg::IDX_STATUS: begin
        next_prdata[torque_sel_pkg::ST_BEHAVIOUR_LSB +: 2] = behaviour;
        next_prdata[torque_sel_pkg::ST_LIMIT_BIT] = torqueLimitActive;
        next_prdata[torque_sel_pkg::ST_MODE_ERR_BIT] = modeError;
      end
      torque_sel_pkg::IDX_TORQUE_OUT: next_prdata[15:0] = torqueCommand;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle so it stands through the access phase
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input sampling, one register stage

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tsel <= 2'b00;
      ssel <= 2'b00;
      sw <= 1'b0;
    end else begin
      tsel <= {torqueSrcSel1, torqueSrcSel0}; // [R4] [R20]
      ssel <= {speedSrcSel1, speedSrcSel0}; // [R20]
      sw <= modeSwitch; // [R20]
    end
  end

  // Sample held one cycle, already inside the +/-10 V span [R1]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      volts <= 16'sh0000;
    end else begin
      volts <= voltsClamped; // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode; zeroed speed has no dual form, so no code exists for it

  always_comb begin
    next_beh = torque_sel_pkg::BEH_POSITION;
    next_zeroed = 1'b0;
    modeError = 1'b0;
    unique case (modeSetting)
      torque_sel_pkg::MODE_PULSE_POS, torque_sel_pkg::MODE_REG_POS:
        next_beh = torque_sel_pkg::BEH_POSITION;
      torque_sel_pkg::MODE_SPEED, torque_sel_pkg::MODE_SPEED_ZERO:
        next_beh = torque_sel_pkg::BEH_SPEED;
      torque_sel_pkg::MODE_TORQUE: next_beh = torque_sel_pkg::BEH_TORQUE;
      torque_sel_pkg::MODE_TORQUE_ZERO: begin
        next_beh = torque_sel_pkg::BEH_TORQUE;
        next_zeroed = 1'b1; // [R2]
      end
      torque_sel_pkg::MODE_POS_SPEED: // [R10] [R16]
        next_beh = sw ? torque_sel_pkg::BEH_SPEED : torque_sel_pkg::BEH_POSITION;
      torque_sel_pkg::MODE_POS_TORQUE: // [R11] [R17]
        next_beh = sw ? torque_sel_pkg::BEH_TORQUE : torque_sel_pkg::BEH_POSITION;
      torque_sel_pkg::MODE_SPEED_TORQUE: // [R12] [R14] [R15]
        next_beh = sw ? torque_sel_pkg::BEH_TORQUE : torque_sel_pkg::BEH_SPEED;
      default: begin
        // Unlisted codes, including any zeroed dual, fall back to position [R13]
        next_beh = torque_sel_pkg::BEH_POSITION;
        modeError = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog scaling and filter

  // Percent = centivolts * setting / 1000 [R7] [R8]
  logic signed [31:0] product;
  assign product = 32'(volts) * $signed({16'h0000, fullScale});
  assign scaled = 16'(product / torque_sel_pkg::VOLT_DIVISOR);

  // First-order IIR; trades a few cycles of lag for noise rejection [R9]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      filtAcc <= 32'sh0000_0000;
    end else begin
      filtAcc <= filtAcc + 32'(scaled) - (filtAcc >>> torque_sel_pkg::FILTER_SHIFT); // [R9]
    end
  end

  always_comb begin
    unique case (tsel)
      2'b00: selected = next_zeroed ? 16'sh0000 :
        16'(filtAcc >>> torque_sel_pkg::FILTER_SHIFT); // [R1] [R2]
      2'b01: selected = presetOne; // [R3] [R5]
      2'b10: selected = presetTwo; // [R3] [R5]
      2'b11: selected = presetThree; // [R3] [R5]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      behaviour <= 2'b00;
    end else begin
      behaviour <= next_beh; // [R10] [R11] [R12]
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      torqueCommand <= 16'sh0000;
      torqueLimit <= 16'sh0000;
      torqueLimitActive <= 1'b0;
    end else begin
      if (next_beh == torque_sel_pkg::BEH_TORQUE) begin
        torqueCommand <= selected; // [R1] [R14]
        torqueLimit <= 16'sh0000;
        torqueLimitActive <= 1'b0;
      end else begin
        torqueCommand <= 16'sh0000;
        torqueLimit <= selected; // [R6] [R8]
        torqueLimitActive <= 1'b1; // [R6]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      speedSelect <= 2'b00;
    end else begin
      speedSelect <= ssel; // [R15] [R16]
    end
  end

  // Analog speed only when both speed selectors are OFF
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      speedFromAnalog <= 1'b0;
    end else begin
      speedFromAnalog <= (next_beh == torque_sel_pkg::BEH_SPEED) && (ssel == 2'b00); // [R16]
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulsePositionActive <= 1'b0;
    end else begin
      pulsePositionActive <= (next_beh == torque_sel_pkg::BEH_POSITION) &&
        (modeSetting != torque_sel_pkg::MODE_REG_POS); // [R16] [R17]
    end
  end

  // Pin function set: one bit per active behaviour plus a dual-mode bit [R19]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      inputMap <= 4'h0;
    end else begin
      inputMap <= {modeSetting == torque_sel_pkg::MODE_POS_SPEED ||
                   modeSetting == torque_sel_pkg::MODE_POS_TORQUE ||
                   modeSetting == torque_sel_pkg::MODE_SPEED_TORQUE,
                   next_beh == torque_sel_pkg::BEH_POSITION,
                   next_beh == torque_sel_pkg::BEH_SPEED,
                   next_beh == torque_sel_pkg::BEH_TORQUE}; // [R19]
    end
  end

endmodule : torque_command_mode_select

////////////////////////////////////////////////////////////////////////////////
// Symmetric saturation shared by the analog and torque preset paths

module sym_clamp #(
  parameter int WIDTH = 16
) (
  // Value and bound
  input wire logic signed [WIDTH-1:0] din,
  input wire logic signed [WIDTH-1:0] bound,
  // Saturated result
  output logic signed [WIDTH-1:0] dout
);

  always_comb begin
    if (din > bound) begin
      dout = bound;
    end else if (din < -bound) begin
      dout = -bound;
    end else begin
      dout = din;
    end
  end

endmodule : sym_clamp

/* core/torque_sel_pkg.sv */
// Constants shared by the torque command select block.
// Assumes a 250 MHz ref_clk and a 16-bit signed analog sample in 1/100 V steps.
package torque_sel_pkg;
  // Printed offsets are not all multiples of four: kept as indices
  localparam logic [15:0] IDX_FULL_SCALE = 16'h0152;
  localparam logic [15:0] IDX_PRESET_ONE = 16'h0020;
  localparam logic [15:0] IDX_PRESET_TWO = 16'h0021;
  localparam logic [15:0] IDX_PRESET_THREE = 16'h0022;
  localparam logic [15:0] IDX_MODE = 16'h0010;
  localparam logic [15:0] IDX_STATUS = 16'h0011;
  localparam logic [15:0] IDX_TORQUE_OUT = 16'h0012;
  localparam logic [15:0] IDX_SPEED_PRESET_ONE = 16'h0023;
  localparam logic [15:0] IDX_SPEED_PRESET_TWO = 16'h0024;
  localparam logic [15:0] IDX_SPEED_PRESET_THREE = 16'h0025;
  localparam int ADDR_SHIFT = 2;
  // Reset values and ranges
  localparam logic [15:0] FULL_SCALE_RESET = 16'h0064;
  localparam logic [15:0] FULL_SCALE_MAX = 16'h03e8;
  localparam logic signed [15:0] PRESET_MAX = 16'sh01d6;
  localparam logic signed [15:0] ANALOG_MAX = 16'sh03e8;
  // Analog input is in centivolts; 10 V full scale = 1000
  localparam logic signed [31:0] VOLT_DIVISOR = 32'sh0000_03e8;
  // Mode codes
  localparam logic [7:0] MODE_PULSE_POS = 8'h00;
  localparam logic [7:0] MODE_REG_POS = 8'h01;
  localparam logic [7:0] MODE_SPEED = 8'h02;
  localparam logic [7:0] MODE_TORQUE = 8'h03;
  localparam logic [7:0] MODE_SPEED_ZERO = 8'h04;
  localparam logic [7:0] MODE_TORQUE_ZERO = 8'h05;
  localparam logic [7:0] MODE_POS_SPEED = 8'h06;
  localparam logic [7:0] MODE_POS_TORQUE = 8'h07;
  localparam logic [7:0] MODE_SPEED_TORQUE = 8'h0a;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Low-pass filter shift (time constant = 2^shift cycles)
  localparam int FILTER_SHIFT = 4;
  // Status fields
  localparam int ST_BEHAVIOUR_LSB = 0;
  localparam int ST_LIMIT_BIT = 2;
  localparam int ST_MODE_ERR_BIT = 3;
  typedef enum logic [1:0] {
    BEH_POSITION,
    BEH_SPEED,
    BEH_TORQUE
  } behaviour_t;
endpackage : torque_sel_pkg

/* tb/torque_command_mode_select_asserts.sv */
// Port checker for the torque command select block.
// Assumes the two-cycle input latency and zero-wait APB of the design.
`timescale 1ns/100ps
module torque_command_mode_select_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bus and inputs
  input wire logic psel,
  input wire logic speedSrcSel0,
  input wire logic speedSrcSel1,
  input wire logic modeSwitch,
  // Results
  input wire logic signed [15:0] torqueCommand,
  input wire logic signed [15:0] torqueLimit,
  input wire logic torqueLimitActive,
  input wire logic [1:0] speedSelect,
  input wire logic speedFromAnalog,
  input wire logic pulsePositionActive,
  input wire logic [1:0] behaviour
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Masks the defaults shown just after reset
  logic [1:0] upCnt;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) upCnt <= 2'h0;
    else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_limit_flag: assert property (upCnt == 2'h3 |->
    torqueLimitActive == (behaviour != torque_sel_pkg::BEH_TORQUE)) else $error("limit flag");
  a_torque_idle: assert property (behaviour != torque_sel_pkg::BEH_TORQUE |->
    torqueCommand == 16'sh0) else $error("torque not idle");
  a_limit_zero: assert property (behaviour == torque_sel_pkg::BEH_TORQUE |->
    torqueLimit == 16'sh0) else $error("limit not zero");
  a_speed_sel_track: assert property (upCnt == 2'h3 |->
    speedSelect == $past({speedSrcSel1, speedSrcSel0}, 2)) else $error("speed select lag");
  a_analog_speed: assert property (speedFromAnalog |->
    behaviour == torque_sel_pkg::BEH_SPEED && speedSelect == 2'h0) else $error("analog speed");
  a_pulse_pos: assert property (pulsePositionActive |->
    behaviour == torque_sel_pkg::BEH_POSITION) else $error("pulse position");
  a_no_zero_dual: assert property (behaviour != 2'h3) else $error("bad behaviour");
  a_beh_quiet: assert property ((!psel && $stable(modeSwitch)) [*4] |->
    $stable(behaviour)) else $error("behaviour moved");
  c_torque: cover property (behaviour == torque_sel_pkg::BEH_TORQUE);
  c_analog_speed: cover property (speedFromAnalog);
  c_limit: cover property (torqueLimitActive && torqueLimit != 16'sh0);
endmodule : torque_command_mode_select_asserts
bind torque_command_mode_select torque_command_mode_select_asserts u_chk (.ref_clk(ref_clk),
  .reset(reset), .psel(psel), .speedSrcSel0(speedSrcSel0), .speedSrcSel1(speedSrcSel1),
  .modeSwitch(modeSwitch), .torqueCommand(torqueCommand), .torqueLimit(torqueLimit),
  .torqueLimitActive(torqueLimitActive), .speedSelect(speedSelect),
  .speedFromAnalog(speedFromAnalog), .pulsePositionActive(pulsePositionActive),
  .behaviour(behaviour));

/* tb/motion_ctrl_model.sv */
// External controller: drives selectors, mode switch and analog level.
// Assumes the bench calls drive after enable; changes land at a rising edge.
`timescale 1ns/100ps
module motion_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Digital and analog outputs
  output logic torqueSrcSel0,
  output logic torqueSrcSel1,
  output logic speedSrcSel0,
  output logic speedSrcSel1,
  output logic modeSwitch,
  output logic signed [15:0] analogVolts
);
  initial {torqueSrcSel1, torqueSrcSel0, speedSrcSel1, speedSrcSel0, modeSwitch} = 5'h0;
  initial analogVolts = 16'sh0;
  // Pattern picks the command source
  task drive(input logic [1:0] t, input logic [1:0] s, input logic sw,
             input logic signed [15:0] v);
    @(posedge ref_clk);
    {torqueSrcSel1, torqueSrcSel0} <= t;
    {speedSrcSel1, speedSrcSel0} <= s;
    modeSwitch <= sw;
    analogVolts <= v;
  endtask : drive
endmodule : motion_ctrl_model

/* tb/test_torque_command_mode_select.sv */
// Self-checking bench for the torque command select block.
// Assumes zero-wait APB and outputs settled a few cycles after inputs.
`timescale 1ns/100ps
module test_torque_command_mode_select;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, er, ok;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic torqueSrcSel0, torqueSrcSel1, speedSrcSel0, speedSrcSel1, modeSwitch;
  logic signed [15:0] analogVolts, torqueCommand, torqueLimit, sv, ev;
  logic torqueLimitActive, speedFromAnalog, pulsePositionActive;
  logic [1:0] speedSelect, behaviour, b0, b1;
  logic [3:0] inputMap;
  logic [7:0] md[3];
  int failures, total_checks, seed;
  int preset[$];
  torque_command_mode_select dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .torqueSrcSel0(torqueSrcSel0),
    .torqueSrcSel1(torqueSrcSel1), .speedSrcSel0(speedSrcSel0), .speedSrcSel1(speedSrcSel1),
    .modeSwitch(modeSwitch), .analogVolts(analogVolts), .torqueCommand(torqueCommand),
    .torqueLimit(torqueLimit), .torqueLimitActive(torqueLimitActive),
    .speedSelect(speedSelect), .speedFromAnalog(speedFromAnalog),
    .pulsePositionActive(pulsePositionActive), .behaviour(behaviour), .inputMap(inputMap));
  motion_ctrl_model ctrl (.ref_clk(ref_clk), .torqueSrcSel0(torqueSrcSel0),
    .torqueSrcSel1(torqueSrcSel1), .speedSrcSel0(speedSrcSel0), .speedSrcSel1(speedSrcSel1),
    .modeSwitch(modeSwitch), .analogVolts(analogVolts));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Holds the request until pready is seen at a rising edge
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h2af15d83;
    md = '{torque_sel_pkg::MODE_TORQUE, torque_sel_pkg::MODE_TORQUE_ZERO,
           torque_sel_pkg::MODE_SPEED};
    {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 64'h0};
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, torque_sel_pkg::IDX_FULL_SCALE, 32'h0);
    chk("fs_reset", rd, 32'h64);
    apb(1'b0, 16'h0030, 32'h0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, torque_sel_pkg::IDX_FULL_SCALE, 32'h4b0);
    apb(1'b0, torque_sel_pkg::IDX_FULL_SCALE, 32'h0);
    chk("fs_sat", rd, 32'h3e8);
    for (int i = 0; i < 3; i++) begin
      preset.push_back($random(seed) % 471);
      apb(1'b1, torque_sel_pkg::IDX_PRESET_ONE + 16'(i), 32'(preset[i]));
    end
    // Torque, zeroed torque, speed; every torque selector pattern
    foreach (md[m]) begin
      apb(1'b1, torque_sel_pkg::IDX_MODE, 32'(md[m]));
      for (int s = 0; s < 4; s++) begin
        ctrl.drive(2'(s), 2'h0, 1'b0, 16'sd500);
        repeat (s == 0 ? 300 : 4) @(posedge ref_clk);
        sv = (m == 2) ? torqueLimit : torqueCommand;
        ev = (s != 0) ? 16'(preset[s - 1]) : (m == 1) ? 16'sh0 : 16'sd500;
        ok = (s == 0 && m != 1) ? (sv >= ev - 16'sd16 && sv <= ev + 16'sd16) : (sv === ev);
        chk("command", ok, 1'b1);
      end
    end
    chk("from_analog", {speedFromAnalog, torqueLimitActive}, 2'h3);
    // Speed/torque dual
    apb(1'b1, torque_sel_pkg::IDX_MODE, 32'h0a);
    for (int sw = 0; sw < 2; sw++) begin
      ctrl.drive(2'h1, 2'($random(seed)), 1'(sw), 16'sh0);
      repeat (4) @(posedge ref_clk);
      chk("st_beh", behaviour, sw ? 2'h2 : 2'h1);
      chk("st_speed", speedSelect, {speedSrcSel1, speedSrcSel0});
      chk("st_map", inputMap, sw ? 4'h9 : 4'ha);
    end
    // Position dual modes toggle between position and the other behaviour
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, torque_sel_pkg::IDX_MODE, k ? 32'h07 : 32'h06);
      ctrl.drive(2'h0, 2'h0, 1'b0, 16'sh0);
      repeat (4) @(posedge ref_clk);
      b0 = behaviour;
      ctrl.drive(2'h0, 2'h0, 1'b1, 16'sh0);
      repeat (4) @(posedge ref_clk);
      b1 = behaviour;
      chk("pulse_pos", pulsePositionActive, b1 == 2'h0);
      ev = k ? 16'h2 : 16'h1;
      ok = (b0 == 2'h0 && b1 == ev[1:0]) || (b1 == 2'h0 && b0 == ev[1:0]);
      chk("pos_dual", ok, 1'b1);
    end
    // Code 08 is no mode at all
    apb(1'b1, torque_sel_pkg::IDX_MODE, 32'h08);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, torque_sel_pkg::IDX_STATUS, 32'h0);
    chk("mode_err", rd[3], 1'b1);
    give_verdict;
  end
endmodule : test_torque_command_mode_select
